// ### verilog/relay_switch_params.svh
`ifndef RELAY_SWITCH_PARAMS_SVH
`define RELAY_SWITCH_PARAMS_SVH

`define NUM_CH             8
`define FRAME_BITS         16
`define BIT_CNT_W          5
`define BIT_CNT_MAX        5'h1F

`define CLK_PERIOD_NS      100
`define OVL_OFF_DELAY_NS   60000
`define OL_DELAY_NS        100000
// longest time rounds down, least time rounds up
`define OVL_CYCLES         (`OVL_OFF_DELAY_NS / `CLK_PERIOD_NS)
`define OL_CYCLES          ((`OL_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// input sync (2) and output flop (1) plus trip cycle eat 4 of the budget
`define OVL_SYNC_MARGIN    4
`define CNT_W              10
`define OVL_TRIP_CNT       (`CNT_W'(`OVL_CYCLES - `OVL_SYNC_MARGIN))
`define OL_TRIP_CNT        (`CNT_W'(`OL_CYCLES - 1))

`define BANK_CFG           1'h0
`define BANK_DIAG          1'h1
`define ADDR_DCCR0         3'h4
`define ADDR_DCCR1         3'h5
`define ADDR_CMD           3'h6

`define CMD_CPL_BIT        0

`define SRC_OFF            2'h0
`define SRC_IN1            2'h1
`define SRC_IN2            2'h2
`define SRC_ON             2'h3

`define SRC_SEL_RST        16'h0000
`define DCEN_RST           8'h00
`define CMD_RST            4'h0

`endif

// ### verilog/relay_switch_pkg.sv
package relay_switch_pkg;

   typedef enum logic [0:0] {SPI_IDLE, SPI_SHIFT} spi_state_type;

   // one 16-bit frame, MSB first on the wire
   typedef struct packed {
      logic       write;
      logic       bank;
      logic [2:0] addr;
      logic [6:0] pad;
      logic [3:0] data;
   } spi_frame_type;

   typedef struct packed {
      logic       cs_n;
      logic       sclk;
      logic       mosi;
      logic       in1;
      logic       in2;
      logic [7:0] overload;
      logic [7:0] overtemp;
      logic [7:0] ol_cmp;
   } pin_sample_type;

endpackage

// ### verilog/relay_switch_protect_diag.sv
// Overview of operation
// RL1 - Each channel has a 2-bit source field, two per register at 1:0 and 3:2: 00 off, 01 input one, 10 input two, 11 on.
// RL2 - An overloaded channel is switched off within the 60 us overload delay and its protection fault flag is set.
// RL3 - After a protective shutdown the channel stays off until the host writes one to the clear-protection-latch bit.
// RL4 - The clear-protection-latch bit returns to zero by itself at the next valid frame after the one that set it.
// RL5 - An over-temperature indication switches the channel off and sets its protection fault flag.
// RL6 - Over-temperature also sets the protection fault flag while the channel is off.
// RL7 - Protection fault flags stay latched until the clear command; reading does not clear them.
// RL8 - The open-load flag stays latched and is cleared by reading the diagnosis register holding it.
// RL9 - No open-load detection takes place while a channel is on.
// RL10 - In the off state the open-load flag is set once the comparator condition persists for the open-load delay.
// RL11 - The diagnosis current of a channel is applied only while its enable bit is set.
// RL12 - The open-load delay lies between 100 and 250 us.
// RL13 - A channel following an input pin is on while that pin is high and off while it is low.
`timescale 1ns/1ps
`include "relay_switch_params.svh"

module relay_switch_protect_diag
   import relay_switch_pkg::*;
(
   input  wire logic                i_core_clk,      // core clock, 10 MHz
   input  wire logic                i_sys_rst,       // sync reset, high
   input  wire logic                i_clk_en,        // freezes state when low
   input  wire logic                i_spi_cs_n,      // spi chip select
   input  wire logic                i_spi_sclk,      // spi clock, sampled
   input  wire logic                i_spi_mosi,      // spi data in
   output      logic                o_spi_miso,      // spi data out
   input  wire logic                i_in1,           // input pin one
   input  wire logic                i_in2,           // input pin two
   input  wire logic [`NUM_CH-1:0]  i_overload,      // overcurrent sense
   input  wire logic [`NUM_CH-1:0]  i_overtemp,      // overtemperature
   input  wire logic [`NUM_CH-1:0]  i_open_load_cmp, // off-state level cmp
   output      logic [`NUM_CH-1:0]  o_channel_on,    // power stage gate
   output      logic [`NUM_CH-1:0]  o_diag_current   // diag current enable
);

   function automatic logic src_decode(input logic [1:0] sel,
                                       input logic       in1,
                                       input logic       in2);
      logic on;
      on = 1'b0;
      case (sel)
         `SRC_OFF: on = 1'b0;
         `SRC_IN1: on = in1;
         `SRC_IN2: on = in2;
         `SRC_ON:  on = 1'b1;
         default:  on = 1'b0;
      endcase
      return on;
   endfunction

   // synchronisers: s1 is read only by s2
   pin_sample_type pin_now;
   pin_sample_type s1_q, s1_d;
   pin_sample_type s2_q, s2_d;
   logic           sclk_prev_q, sclk_prev_d;

   always_comb
   begin
      pin_now     = '{i_spi_cs_n, i_spi_sclk, i_spi_mosi, i_in1, i_in2,
                      i_overload, i_overtemp, i_open_load_cmp};
      s1_d        = pin_now;
      s2_d        = s1_q;
      sclk_prev_d = s2_q.sclk;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         // select idles high, so no false frame start after reset
         s1_q        <= '{cs_n: 1'b1, default: '0};
         s2_q        <= '{cs_n: 1'b1, default: '0};
         sclk_prev_q <= 1'b0;
      end
      else if (i_clk_en)
      begin
         s1_q        <= s1_d;
         s2_q        <= s2_d;
         sclk_prev_q <= sclk_prev_d;
      end
   end

   // register file
   logic [15:0]         src_sel_q, src_sel_d;
   logic [`NUM_CH-1:0]  dcen_q, dcen_d;
   logic [3:0]          cmd_q, cmd_d;
   logic [`NUM_CH-1:0]  fault_q, fault_d;
   logic [`NUM_CH-1:0]  ol_q, ol_d;

   function automatic logic [3:0] read_reg(input spi_frame_type f);
      logic [3:0] r;
      r = 4'h0;
      if (f.bank == `BANK_DIAG)
      begin
         if (!f.addr[2])
            r = {ol_q[{f.addr[1:0], 1'b1}], fault_q[{f.addr[1:0], 1'b1}],
                 ol_q[{f.addr[1:0], 1'b0}], fault_q[{f.addr[1:0], 1'b0}]};
      end
      else
      begin
         case (f.addr)
            `ADDR_DCCR0: r = dcen_q[3:0];
            `ADDR_DCCR1: r = dcen_q[7:4];
            `ADDR_CMD:   r = cmd_q;
            default:     r = f.addr[2] ? 4'h0
                                       : src_sel_q[{f.addr[1:0], 2'h0} +: 4];
         endcase
      end
      return r;
   endfunction

   // spi slave, mode 0, response of a frame goes out in the next one
   spi_state_type         state_q, state_d;
   logic [`BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
   logic [15:0]           shin_q, shin_d;
   logic [15:0]           shout_q, shout_d;
   logic                  miso_q, miso_d;
   logic                  frame_valid;
   spi_frame_type         frame;
   logic                  sclk_rise;
   logic                  sclk_fall;

   always_comb
   begin
      state_d     = state_q;
      bit_cnt_d   = bit_cnt_q;
      shin_d      = shin_q;
      shout_d     = shout_q;
      miso_d      = miso_q;
      frame_valid = 1'b0;
      frame       = shin_q;
      sclk_rise   = s2_q.sclk & ~sclk_prev_q;
      sclk_fall   = ~s2_q.sclk & sclk_prev_q;
      case (state_q)
         SPI_IDLE:
         begin
            if (!s2_q.cs_n)
            begin
               state_d   = SPI_SHIFT;
               bit_cnt_d = '0;
               miso_d    = shout_q[15];
            end
         end
         SPI_SHIFT:
         begin
            if (s2_q.cs_n)
            begin
               state_d = SPI_IDLE;
               // only an exact-length frame is valid
               if (bit_cnt_q == `BIT_CNT_W'(`FRAME_BITS))
               begin
                  frame_valid = 1'b1;
                  shout_d     = {frame.write, frame.bank, frame.addr,
                                 7'h00, read_reg(frame)};
               end
            end
            else if (sclk_rise)
            begin
               shin_d = {shin_q[14:0], s2_q.mosi};
               if (bit_cnt_q != `BIT_CNT_MAX)
                  bit_cnt_d = bit_cnt_q + `BIT_CNT_W'(1);
            end
            else if (sclk_fall)
            begin
               shout_d = {shout_q[14:0], 1'b0};
               miso_d  = shout_q[14];
            end
         end
         default: state_d = SPI_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         state_q   <= SPI_IDLE;
         bit_cnt_q <= '0;
         shin_q    <= '0;
         shout_q   <= '0;
         miso_q    <= 1'b0;
      end
      else if (i_clk_en)
      begin
         state_q   <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shin_q    <= shin_d;
         shout_q   <= shout_d;
         miso_q    <= miso_d;
      end
   end

   logic cfg_write;
   logic diag_read;
   logic cpl_pulse;

   always_comb
   begin
      src_sel_d = src_sel_q;
      dcen_d    = dcen_q;
      cmd_d     = cmd_q;
      cfg_write = frame_valid & frame.write & (frame.bank == `BANK_CFG);
      diag_read = frame_valid & ~frame.write & (frame.bank == `BANK_DIAG);
      cpl_pulse = 1'b0;
      if (frame_valid)
         cmd_d[`CMD_CPL_BIT] = 1'b0;                          // [RL4]
      if (cfg_write)
      begin
         case (frame.addr)
            `ADDR_DCCR0: dcen_d[3:0] = frame.data;            // [RL11]
            `ADDR_DCCR1: dcen_d[7:4] = frame.data;            // [RL11]
            `ADDR_CMD:
            begin
               cmd_d     = frame.data;
               cpl_pulse = frame.data[`CMD_CPL_BIT];          // [RL3]
            end
            default:
               if (!frame.addr[2])
                  src_sel_d[{frame.addr[1:0], 2'h0} +: 4] = frame.data; // [RL1]
         endcase
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         src_sel_q <= `SRC_SEL_RST;
         dcen_q    <= `DCEN_RST;
         cmd_q     <= `CMD_RST;
      end
      else if (i_clk_en)
      begin
         src_sel_q <= src_sel_d;
         dcen_q    <= dcen_d;
         cmd_q     <= cmd_d;
      end
   end

   // protection and diagnosis per channel
   logic [`CNT_W-1:0]  ovl_cnt_q [`NUM_CH];
   logic [`CNT_W-1:0]  ovl_cnt_d [`NUM_CH];
   logic [`CNT_W-1:0]  ol_cnt_q  [`NUM_CH];
   logic [`CNT_W-1:0]  ol_cnt_d  [`NUM_CH];
   logic [`NUM_CH-1:0] on_q, on_d;
   logic [`NUM_CH-1:0] cmd_on;
   logic [`NUM_CH-1:0] ol_clr;

   always_comb
   begin
      fault_d = fault_q;
      ol_d    = ol_q;
      on_d    = on_q;
      cmd_on  = '0;
      ol_clr  = '0;
      for (int i = 0; i < `NUM_CH; i++)
      begin
         ovl_cnt_d[i] = ovl_cnt_q[i];
         ol_cnt_d[i]  = ol_cnt_q[i];
         cmd_on[i]    = src_decode(src_sel_q[2*i +: 2],
                                   s2_q.in1, s2_q.in2);       // [RL1] [RL13]
         // clear first, so a same-cycle set wins
         if (cpl_pulse)
            fault_d[i] = 1'b0;                                // [RL3] [RL7]
         if (on_q[i] && s2_q.overload[i])
         begin
            if (ovl_cnt_q[i] == `OVL_TRIP_CNT)
               fault_d[i] = 1'b1;                             // [RL2]
            else
               ovl_cnt_d[i] = ovl_cnt_q[i] + `CNT_W'(1);
         end
         else
            ovl_cnt_d[i] = '0;
         if (s2_q.overtemp[i])
            fault_d[i] = 1'b1;                                // [RL5] [RL6]
         ol_clr[i] = diag_read && !frame.addr[2] &&
                     (frame.addr[1:0] == 2'(i / 2));
         if (ol_clr[i])
            ol_d[i] = 1'b0;                                   // [RL8]
         // off-state only; counter held at zero while on
         if (!on_q[i] && s2_q.ol_cmp[i])
         begin                                                // [RL9]
            if (ol_cnt_q[i] == `OL_TRIP_CNT)
               ol_d[i] = 1'b1;                                // [RL10] [RL12]
            else
               ol_cnt_d[i] = ol_cnt_q[i] + `CNT_W'(1);
         end
         else
            ol_cnt_d[i] = '0;
         on_d[i] = cmd_on[i] & ~fault_d[i];                   // [RL3] [RL5]
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         fault_q <= '0;
         ol_q    <= '0;
         on_q    <= '0;
         for (int i = 0; i < `NUM_CH; i++)
         begin
            ovl_cnt_q[i] <= '0;
            ol_cnt_q[i]  <= '0;
         end
      end
      else if (i_clk_en)
      begin
         fault_q <= fault_d;
         ol_q    <= ol_d;
         on_q    <= on_d;
         for (int i = 0; i < `NUM_CH; i++)
         begin
            ovl_cnt_q[i] <= ovl_cnt_d[i];
            ol_cnt_q[i]  <= ol_cnt_d[i];
         end
      end
   end

   assign o_spi_miso     = miso_q;
   assign o_channel_on   = on_q;
   assign o_diag_current = dcen_q;                            // [RL11]

endmodule // relay_switch_protect_diag

// ### dv/relay_switch_protect_diag_sva.sv
`timescale 1ns/1ps
`include "relay_switch_params.svh"
module relay_switch_protect_diag_sva (
   input  wire logic               i_core_clk,     // core clock
   input  wire logic               i_sys_rst,      // sync reset
   input  wire logic               i_spi_cs_n,     // spi select
   input  wire logic [`NUM_CH-1:0] i_overload,     // overcurrent
   input  wire logic [`NUM_CH-1:0] i_overtemp,     // overheat
   input  wire logic [`NUM_CH-1:0] o_channel_on,   // stage gates
   input  wire logic [`NUM_CH-1:0] o_diag_current  // diag current
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_hot(h);
      h[*3];
   endsequence

   // cycles channel 0 has been on into an overload, pin side
   logic [9:0] ovl_q;
   logic [9:0] ovl_d;
   always_comb
      ovl_d = (i_overload[0] && o_channel_on[0]) ? ovl_q + 10'h001 : 10'h000;
   always_ff @(posedge i_core_clk)
      ovl_q <= i_sys_rst ? 10'h000 : ovl_d;

   a_ovl_count_max:
      assert property (ovl_q <= 10'h258)
      else $error("overloaded channel stayed on too long");
   a_rst_outputs_low:
      assert property ($fell(i_sys_rst) |->
                       o_channel_on == 8'h00 && o_diag_current == 8'h00)
      else $error("outputs not cleared by reset");
   a_diag_frame_end:
      assert property ($changed(o_diag_current) |->
                       i_spi_cs_n && $past(i_spi_cs_n, 2))
      else $error("diag current changed inside a frame");
   a_diag_quiet_frame:
      assert property ((!i_spi_cs_n)[*4] |=> $stable(o_diag_current))
      else $error("diag current moved while selected");

   for (genvar c = 0; c < `NUM_CH; c++)
   begin : g_ch
      a_ovl_off_bound:
         assert property ($rose(i_overload[c]) |->
                          ##[1:600] (!o_channel_on[c] || !i_overload[c]))
         else $error("overload did not switch channel off in time");
      a_ovl_latch_off:
         assert property (($fell(o_channel_on[c]) && i_overload[c]) |=>
                          (!o_channel_on[c])[*8])
         else $error("channel came back without latch clear");
      a_temp_off_fast:
         assert property (s_hot(i_overtemp[c]) |-> ##[0:4] !o_channel_on[c])
         else $error("overheated channel not switched off");
      a_temp_hold_off:
         assert property (i_overtemp[c][*8] |-> !o_channel_on[c])
         else $error("overheated channel is on");
   end
endmodule // relay_switch_protect_diag_sva

bind relay_switch_protect_diag relay_switch_protect_diag_sva u_sva (
   .i_core_clk, .i_sys_rst, .i_spi_cs_n, .i_overload, .i_overtemp,
   .o_channel_on, .o_diag_current);

// ### dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic i_core_clk,  // bench core clock
   input  wire logic i_miso,      // device data out
   output      logic o_cs_n,      // select, active low
   output      logic o_sclk,      // link clock, idles low
   output      logic o_mosi       // data to device
);
   initial
   begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b1;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge i_core_clk);
   endtask

   // half link period is four core cycles, 800 ns period
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      o_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         o_mosi = w[i];
         wait_cyc(4);
         o_sclk = 1'b1;
         r[i] = i_miso;
         wait_cyc(4);
         o_sclk = 1'b0;
      end
      wait_cyc(4);
      o_cs_n = 1'b1;
      // released line must not keep showing the last bit
      o_mosi = ~o_mosi;
      wait_cyc(8);
   endtask
endmodule // spi_host_model

// ### dv/relay_switch_protect_diag_test.sv
`timescale 1ns/1ps
module relay_switch_protect_diag_test;
   logic        i_core_clk = 1'b0;
   logic        i_sys_rst  = 1'b1;
   logic        cs_n, sclk, mosi, miso, in1 = 1'b0, in2 = 1'b0;
   logic [7:0]  ovl = 8'h00, hot = 8'h00, olc = 8'h00, on, dcur;
   logic [15:0] rsp;
   int          mismatches = 0;
   int          num_checks = 0;

   always #50 i_core_clk = ~i_core_clk;

   relay_switch_protect_diag uut (.i_core_clk, .i_sys_rst, .i_clk_en(1'b1),
      .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_mosi(mosi),
      .o_spi_miso(miso), .i_in1(in1), .i_in2(in2), .i_overload(ovl),
      .i_overtemp(hot), .i_open_load_cmp(olc), .o_channel_on(on),
      .o_diag_current(dcur));
   spi_host_model host (.i_core_clk, .i_miso(miso), .o_cs_n(cs_n),
      .o_sclk(sclk), .o_mosi(mosi));

   task automatic cmp(input string what, input logic [7:0] exp, got);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [3:0] d);
      host.xfer({2'h2, a, 7'h00, d}, rsp);
   endtask

   // answer arrives in the next frame; addr 7 read only clears the clear-protection-latch bit
   task automatic rd(input logic b, input logic [2:0] a, output logic [7:0] d);
      host.xfer({1'b0, b, a, 7'h00, 4'h0}, rsp);
      host.xfer(16'h3800, rsp);
      d = {4'h0, rsp[3:0]};
   endtask

   task automatic wait_on(input logic [7:0] m, v, input int lim);
      for (int n = 0; (on & m) !== v; n++)
      begin
         if (n == lim)
         begin
            mismatches++;
            complete_run;
         end
         @(negedge i_core_clk);
      end
   endtask

   task automatic t_modes;
      logic [7:0] d;
      logic       e;
      for (int m = 0; m < 4; m++)
      begin
         wr(3'h0, 4'(m << 2));
         rd(1'b0, 3'h0, d);
         cmp("source reg", 8'(m << 2), d);
         for (int p = 0; p < 4; p++)
         begin
            {in2, in1} = 2'(p);
            repeat (6) @(negedge i_core_clk);
            e = (m == 3) || (m == 1 && in1) || (m == 2 && in2);
            cmp("mode out", {6'h00, e, 1'b0}, on);
         end
      end
      {in2, in1} = 2'h0;
   endtask

   task automatic t_ovl;
      logic [7:0] d;
      wr(3'h0, 4'h3);
      wait_on(8'h01, 8'h01, 20);
      ovl[0] = 1'b1;
      wait_on(8'h01, 8'h00, 600);
      ovl[0] = 1'b0;
      repeat (20) @(negedge i_core_clk);
      cmp("latched off", 8'h00, on);
      rd(1'b1, 3'h0, d);
      cmp("fault flag", 8'h01, d);
      rd(1'b1, 3'h0, d);
      cmp("fault kept", 8'h01, d);
      wr(3'h6, 4'h1);
      wait_on(8'h01, 8'h01, 20);
      rd(1'b0, 3'h6, d);
      cmp("clear bit set", 8'h01, d);
      rd(1'b0, 3'h6, d);
      cmp("clear bit", 8'h00, d);
      rd(1'b1, 3'h0, d);
      cmp("fault cleared", 8'h00, d);
   endtask

   task automatic t_temp;
      logic [7:0] d;
      hot[1] = 1'b1;
      repeat (8) @(negedge i_core_clk);
      rd(1'b1, 3'h0, d);
      cmp("off hot flag", 8'h04, d);
      wr(3'h0, 4'hF);
      repeat (8) @(negedge i_core_clk);
      cmp("hot held off", 8'h01, on);
      hot = 8'h03;
      wait_on(8'h01, 8'h00, 10);
      hot = 8'h00;
      wr(3'h6, 4'h1);
      repeat (8) @(negedge i_core_clk);
      cmp("after clear", 8'h03, on);
      wr(3'h0, 4'h0);
   endtask

   task automatic t_open;
      logic [7:0] d;
      wr(3'h1, 4'hC);
      olc = 8'h0C;
      repeat (900) @(negedge i_core_clk);
      olc = 8'h00;
      rd(1'b1, 3'h1, d);
      cmp("ol too early", 8'h00, d);
      olc = 8'h0C;
      repeat (1100) @(negedge i_core_clk);
      olc = 8'h00;
      rd(1'b1, 3'h1, d);
      cmp("ol set off only", 8'h02, d);
      rd(1'b1, 3'h1, d);
      cmp("ol read clear", 8'h00, d);
      wr(3'h1, 4'h0);
   endtask

   task automatic t_diag;
      for (int i = 0; i < 3; i++)
      begin
         wr(3'h4, 4'(5 << i));
         wr(3'h5, ~4'(5 << i));
         cmp("diag current", {~4'(5 << i), 4'(5 << i)}, dcur);
      end
      wr(3'h4, 4'h0);
      wr(3'h5, 4'h0);
      cmp("diag off", 8'h00, dcur);
   endtask

   initial
   begin
      logic [7:0] d;
      repeat (2) @(negedge i_core_clk);
      i_sys_rst = 1'b0;
      repeat (4) @(negedge i_core_clk);
      cmp("reset gates", 8'h00, on);
      rd(1'b0, 3'h0, d);
      cmp("reset source", 8'h00, d);
      t_modes();
      t_ovl();
      t_temp();
      t_open();
      t_diag();
      complete_run();
   end
endmodule // relay_switch_protect_diag_test
